// ===== mstx_pkg.sv
package mstx_pkg;

  localparam int DATA_W = 8;
  localparam int PROG_W = 16;
  localparam int PADDR_W = 16;
  localparam int BIT_SEL_W = 3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [7:0] TPTR_RESET = 8'h00;
  localparam logic [7:0] TLATCH_RESET = 8'h00;
  localparam logic [1:0] SKIP_SLOTS = 2'h2;

  typedef enum logic [3:0] {
    MSTX_OP_NONE,
    MSTX_OP_SWAP_WREG,
    MSTX_OP_SKIP_NULL,
    MSTX_OP_COPY_SKIP_NULL,
    MSTX_OP_SKIP_BIT_CLEAR,
    MSTX_OP_TRD_PAGED,
    MSTX_OP_TRD_FINAL,
    MSTX_OP_TRD_PAGED_INC,
    MSTX_OP_TRD_FINAL_INC,
    MSTX_OP_XOR_WREG,
    MSTX_OP_XOR_MEM
  } mstx_op_t;

  typedef struct packed {
    mstx_op_t op;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [DATA_W-1:0] operand;
  } mstx_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } mstx_wr_t;

endpackage : mstx_pkg

// ===== mstx_alu.sv
`timescale 1ns/1ps
`default_nettype none

module mstx_alu
  import mstx_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire mstx_op_t op,
  input wire logic [W-1:0] operand,
  input wire logic [W-1:0] wreg,
  input wire logic [BIT_SEL_W-1:0] bit_sel,
  output logic [W-1:0] result,
  output logic skip,
  output logic zero
);

  always_comb begin
    result = operand;
    skip = 1'b0;
    case (op)
      MSTX_OP_SWAP_WREG: begin
        result = {operand[3:0], operand[7:4]};
      end
      MSTX_OP_SKIP_NULL: begin
        skip = (operand == ZERO_BYTE);
      end
      MSTX_OP_COPY_SKIP_NULL: begin
        skip = (operand == ZERO_BYTE);
      end
      MSTX_OP_SKIP_BIT_CLEAR: begin
        skip = ~operand[bit_sel];
      end
      MSTX_OP_XOR_WREG, MSTX_OP_XOR_MEM: begin
        result = wreg ^ operand;
      end
      default: begin
        result = operand;
      end
    endcase
  end

  assign zero = (result == ZERO_BYTE);

endmodule : mstx_alu

`default_nettype wire

// ===== mstx_exec.sv
`timescale 1ns/1ps
`default_nettype none

module mstx_exec
  import mstx_pkg::*;
#(
  parameter int PAW = PADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire mstx_req_t req,
  input wire logic req_valid,
  input wire logic [DATA_W-1:0] tptr_low_wr,
  input wire logic tptr_low_we,
  input wire logic [DATA_W-1:0] tptr_high_wr,
  input wire logic tptr_high_we,
  input wire logic [PROG_W-1:0] prog_rdata,
  output logic [PAW-1:0] prog_addr,
  output logic prog_re,
  output mstx_wr_t mem_wr,
  output logic [DATA_W-1:0] wreg,
  output logic zero_flag,
  output logic zero_we,
  output logic [DATA_W-1:0] table_high_latch,
  output logic [DATA_W-1:0] table_pointer_low,
  output logic [DATA_W-1:0] table_pointer_high,
  output logic skip_slot,
  output logic busy
);

  typedef enum logic [1:0] {MSTX_IDLE, MSTX_TRD, MSTX_SKIP} mstx_state_t;

  mstx_state_t state_q;
  logic [1:0] skip_cnt_q;
  logic [DATA_W-1:0] alu_res;
  logic alu_skip;
  logic alu_zero;
  logic is_trd;
  logic is_inc;
  logic is_final;
  logic [DATA_W-1:0] tpl_next;

  mstx_alu #(.W(DATA_W)) u_alu (
    .op(req.op),
    .operand(req.operand),
    .wreg(wreg),
    .bit_sel(req.bit_sel),
    .result(alu_res),
    .skip(alu_skip),
    .zero(alu_zero)
  );

  assign is_trd = (req.op == MSTX_OP_TRD_PAGED) || (req.op == MSTX_OP_TRD_FINAL) ||
                  (req.op == MSTX_OP_TRD_PAGED_INC) || (req.op == MSTX_OP_TRD_FINAL_INC);
  assign is_inc = (req.op == MSTX_OP_TRD_PAGED_INC) || (req.op == MSTX_OP_TRD_FINAL_INC);
  assign is_final = (req.op == MSTX_OP_TRD_FINAL) || (req.op == MSTX_OP_TRD_FINAL_INC);
  assign tpl_next = is_inc ? table_pointer_low + 8'h01 : table_pointer_low;

  wire logic accept = req_valid && (state_q == MSTX_IDLE);

  // Sequencer; requests offered while busy are ignored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= MSTX_IDLE;
      skip_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        MSTX_IDLE: begin
          if (accept && is_trd) begin
            state_q <= MSTX_TRD;
          end else if (accept && alu_skip) begin
            state_q <= MSTX_SKIP;
            skip_cnt_q <= SKIP_SLOTS;
          end
        end
        MSTX_TRD: begin
          state_q <= MSTX_IDLE;
        end
        MSTX_SKIP: begin
          skip_cnt_q <= skip_cnt_q - 2'h1;
          if (skip_cnt_q == 2'h1) begin
            state_q <= MSTX_IDLE;
          end
        end
        default: begin
          state_q <= MSTX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      skip_slot <= 1'b0;
    end else begin
      busy <= (state_q == MSTX_IDLE) ? (accept && (is_trd || alu_skip)) :
              !((state_q == MSTX_TRD) || (state_q == MSTX_SKIP && skip_cnt_q == 2'h1));
      skip_slot <= (state_q == MSTX_IDLE) ? (accept && !is_trd && alu_skip) :
                   (state_q == MSTX_SKIP && skip_cnt_q != 2'h1);
    end
  end

  // Table pointers: a core write to the low pointer loses to a preincrement in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      table_pointer_low <= TPTR_RESET;
      table_pointer_high <= TPTR_RESET;
    end else begin
      if (accept && is_trd && is_inc) begin
        table_pointer_low <= tpl_next;
      end else if (tptr_low_we) begin
        table_pointer_low <= tptr_low_wr;
      end
      if (tptr_high_we) begin
        table_pointer_high <= tptr_high_wr;
      end
    end
  end

  // Program memory address: final page keeps all upper bits high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_addr <= '0;
      prog_re <= 1'b0;
    end else begin
      prog_re <= accept && is_trd;
      if (accept && is_trd) begin
        if (is_final) begin
          prog_addr <= {{(PAW-DATA_W){1'b1}}, tpl_next};
        end else begin
          prog_addr <= {table_pointer_high[PAW-DATA_W-1:0], tpl_next};
        end
      end
    end
  end

  // Data memory write and table-high latch; program data is sampled in the same cycle that prog_re is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wr <= '0;
      table_high_latch <= TLATCH_RESET;
    end else begin
      mem_wr.valid <= 1'b0;
      if (state_q == MSTX_TRD) begin
        mem_wr.valid <= 1'b1;
        mem_wr.data <= prog_rdata[DATA_W-1:0];
        table_high_latch <= prog_rdata[PROG_W-1:DATA_W];
      end else if (accept && req.op == MSTX_OP_XOR_MEM) begin
        mem_wr.valid <= 1'b1;
        mem_wr.data <= alu_res;
      end
    end
  end

  // Working register and zero flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wreg <= WREG_RESET;
      zero_flag <= 1'b0;
      zero_we <= 1'b0;
    end else begin
      zero_we <= 1'b0;
      if (accept) begin
        case (req.op)
          MSTX_OP_SWAP_WREG, MSTX_OP_COPY_SKIP_NULL: begin
            wreg <= alu_res;
          end
          MSTX_OP_XOR_WREG: begin
            wreg <= alu_res;
            zero_flag <= alu_zero;
            zero_we <= 1'b1;
          end
          MSTX_OP_XOR_MEM: begin
            zero_flag <= alu_zero;
            zero_we <= 1'b1;
          end
          default: begin
            wreg <= wreg;
          end
        endcase
      end
    end
  end

  AST_SWAP: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_SWAP_WREG |=> wreg == {$past(req.operand[3:0]), $past(req.operand[7:4])} && !zero_we)
    else $error("swap result wrong");
  AST_SKIP_NULL: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_SKIP_NULL && req.operand == ZERO_BYTE |=> skip_slot ##1 skip_slot ##1 !busy)
    else $error("null skip missing");
  AST_NO_SKIP: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_SKIP_NULL && req.operand != ZERO_BYTE |=> !skip_slot && !busy)
    else $error("spurious skip");
  AST_SKIP_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(skip_slot) |-> busy [*2] ##1 !busy)
    else $error("skip length wrong");
  AST_COPY: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_COPY_SKIP_NULL |=> wreg == $past(req.operand) && skip_slot == (wreg == ZERO_BYTE))
    else $error("copy skip wrong");
  AST_BIT: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_SKIP_BIT_CLEAR |=> skip_slot == !$past(req.operand[req.bit_sel]))
    else $error("bit skip wrong");
  AST_TRD_PAGED: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_TRD_PAGED |=> prog_re && prog_addr[7:0] == $past(table_pointer_low)
      && prog_addr[PAW-1:DATA_W] == $past(table_pointer_high[PAW-DATA_W-1:0])
      ##1 mem_wr.valid && mem_wr.data == $past(prog_rdata[7:0]) && table_high_latch == $past(prog_rdata[15:8]))
    else $error("paged read wrong");
  AST_TRD_FINAL: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_TRD_FINAL |=> prog_addr[PAW-1:DATA_W] == '1
      && prog_addr[7:0] == $past(table_pointer_low))
    else $error("final page address wrong");
  AST_TRD_INC: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_TRD_PAGED_INC |=> table_pointer_low == $past(table_pointer_low) + 8'h01
      && prog_addr[7:0] == table_pointer_low)
    else $error("preincrement wrong");
  AST_TRD_FINAL_INC: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_TRD_FINAL_INC |=> ##1 table_high_latch == $past(prog_rdata[15:8]))
    else $error("latch not loaded");
  AST_XOR_WREG: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_XOR_WREG |=> wreg == ($past(wreg) ^ $past(req.operand)) && zero_we && !mem_wr.valid
      && zero_flag == (wreg == ZERO_BYTE))
    else $error("xor to register wrong");
  AST_XOR_MEM: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_XOR_MEM |=> mem_wr.valid && mem_wr.data == ($past(wreg) ^ $past(req.operand))
      && wreg == $past(wreg))
    else $error("xor to memory wrong");
  AST_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    accept && req.op == MSTX_OP_XOR_MEM |=> zero_flag == (mem_wr.data == ZERO_BYTE))
    else $error("zero flag wrong");

endmodule : mstx_exec

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import mstx_pkg::*;;
  typedef struct {
    int due;
    logic [7:0] w, md, lat, tpl, tph;
    logic z, zw, mv, sk, bz, re;
    logic [15:0] pa;
  } mstx_note_t;
  logic ref_clk, rst, req_valid, tptr_low_we, tptr_high_we, prog_re, zero_flag, zero_we, skip_slot, busy;
  logic [7:0] tptr_low_wr, tptr_high_wr, wreg, table_high_latch, table_pointer_low, table_pointer_high;
  logic [15:0] prog_rdata, prog_addr;
  mstx_req_t req;
  mstx_wr_t mem_wr;
  mstx_note_t notes[$];
  mstx_note_t n;
  logic [7:0] m_w, m_lat, m_tpl, m_tph;
  logic m_z;
  int cyc, n_errors, checked;
  integer seed = 32'h08907C42;
  // Combinational program store on the registered address
  function automatic logic [15:0] rom(input logic [15:0] a);
    return {a[7:0] ^ 8'h5A, a[15:8] ^ a[7:0]};
  endfunction : rom
  assign prog_rdata = rom(prog_addr);
  mstx_exec u_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .req_valid(req_valid), .tptr_low_wr(tptr_low_wr),
    .tptr_low_we(tptr_low_we), .tptr_high_wr(tptr_high_wr), .tptr_high_we(tptr_high_we), .prog_rdata(prog_rdata),
    .prog_addr(prog_addr), .prog_re(prog_re), .mem_wr(mem_wr), .wreg(wreg), .zero_flag(zero_flag),
    .zero_we(zero_we), .table_high_latch(table_high_latch), .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high), .skip_slot(skip_slot), .busy(busy));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Full snapshot of the model; pulses default low
  function automatic mstx_note_t mk(input int due);
    return '{due: due, w: m_w, md: 8'h00, lat: m_lat, tpl: m_tpl, tph: m_tph, z: m_z, zw: 1'b0, mv: 1'b0,
      sk: 1'b0, bz: 1'b0, re: 1'b0, pa: 16'h0000};
  endfunction : mk
  always @(posedge ref_clk) begin
    #1;
    cyc++;
    while (notes.size() > 0 && notes[0].due == cyc) begin
      n = notes.pop_front();
      chk(wreg, n.w);
      chk(zero_flag, n.z);
      chk(zero_we, n.zw);
      chk(mem_wr.valid, n.mv);
      if (n.mv) chk(mem_wr.data, n.md);
      chk(table_high_latch, n.lat);
      chk({table_pointer_high, table_pointer_low}, {n.tph, n.tpl});
      chk({skip_slot, busy, prog_re}, {n.sk, n.bz, n.re});
      if (n.re) chk(prog_addr, n.pa);
    end
  end
  task automatic set_ptr(input logic [7:0] l, input logic [7:0] h);
    req_valid <= 1'b0;
    {tptr_low_wr, tptr_high_wr, tptr_low_we, tptr_high_we} <= {l, h, 2'b11};
    @(posedge ref_clk);
    {tptr_low_we, tptr_high_we} <= 2'b00;
    m_tpl = l;
    m_tph = h;
    notes.push_back(mk(cyc + 1));
  endtask : set_ptr
  // Called at an edge; simple ops leave valid up for back-to-back issue
  task automatic do_op(input mstx_op_t o, input logic [2:0] b, input logic [7:0] d);
    int c;
    logic sk, zw, mv, re;
    logic [7:0] r;
    logic [15:0] pa, wd;
    c = cyc;
    {sk, zw, mv, re, r, pa} = '0;
    req <= '{op: o, bit_sel: b, operand: d};
    req_valid <= 1'b1;
    case (o)
      MSTX_OP_SWAP_WREG: m_w = {d[3:0], d[7:4]};
      MSTX_OP_SKIP_NULL: sk = (d == ZERO_BYTE);
      MSTX_OP_COPY_SKIP_NULL: begin
        m_w = d;
        sk = (d == ZERO_BYTE);
      end
      MSTX_OP_SKIP_BIT_CLEAR: sk = ~d[b];
      MSTX_OP_XOR_WREG, MSTX_OP_XOR_MEM: begin
        r = m_w ^ d;
        m_z = (r == ZERO_BYTE);
        zw = 1'b1;
        if (o == MSTX_OP_XOR_WREG) m_w = r;
        else mv = 1'b1;
      end
      default: begin
        if (o == MSTX_OP_TRD_PAGED_INC || o == MSTX_OP_TRD_FINAL_INC) m_tpl++;
        re = 1'b1;
        pa = (o == MSTX_OP_TRD_FINAL || o == MSTX_OP_TRD_FINAL_INC) ? {8'hFF, m_tpl} : {m_tph, m_tpl};
      end
    endcase
    n = mk(c + 2);
    {n.zw, n.mv, n.md, n.re, n.pa, n.sk, n.bz} = {zw, mv, r, re, pa, sk, sk | re};
    notes.push_back(n);
    if (re) begin
      wd = rom(pa);
      m_lat = wd[15:8];
      n = mk(c + 3);
      {n.mv, n.md} = {1'b1, wd[7:0]};
      notes.push_back(n);
    end
    if (sk) begin
      n.due = c + 3;
      notes.push_back(n);
      notes.push_back(mk(c + 4));
    end
    @(posedge ref_clk);
    if (sk || re) begin
      // Busy ops: drop valid so the edge where busy falls cannot retake it
      req_valid <= 1'b0;
      repeat (sk ? 2 : 1) @(posedge ref_clk);
    end
  endtask : do_op
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end
  initial begin
    {rst, req_valid, tptr_low_we, tptr_high_we, tptr_low_wr, tptr_high_wr} = {2'b10, 2'b00, 16'h0000};
    req = '0;
    {m_w, m_lat, m_tpl, m_tph, m_z} = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    notes.push_back(mk(cyc + 1));
    set_ptr(8'hFF, 8'h12);
    for (int k = 1; k <= 10; k++) do_op(mstx_op_t'(k[3:0]), 3'h0, 8'h00);
    do_op(MSTX_OP_SKIP_BIT_CLEAR, 3'h7, 8'h7F);
    $display("test directed done");
    for (int i = 0; i < 400; i++) begin
      if ($random(seed) % 8 == 0) set_ptr(8'($random(seed)), 8'($random(seed)));
      do_op(mstx_op_t'(4'(1 + {$random(seed)} % 10)), 3'($random(seed)),
        ($random(seed) % 4 == 0) ? 8'h00 : 8'($random(seed)));
    end
    req_valid <= 1'b0;
    repeat (6) @(posedge ref_clk);
    // A note left behind means its cycle was never matched
    chk(16'(notes.size()), 16'h0000);
    $display("test random done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
